// File: dms_pkg.sv
// constants and types shared by the dll mode switch sequencer
package dms_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BA_W   = 3;
  localparam int CNT_W  = 10;
  localparam int DIV_W  = 8;
  localparam int REG_AW = 4;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // software register indices
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] REG_CTRL     = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS   = 4'h1;
  localparam logic [REG_AW-1:0] REG_DIV_NEW  = 4'h2;
  localparam logic [REG_AW-1:0] REG_DIV_CUR  = 4'h3;
  localparam logic [REG_AW-1:0] REG_T_MOD    = 4'h4;
  localparam logic [REG_AW-1:0] REG_T_MRD    = 4'h5;
  localparam logic [REG_AW-1:0] REG_T_XS     = 4'h6;
  localparam logic [REG_AW-1:0] REG_T_CKSRE  = 4'h7;
  localparam logic [REG_AW-1:0] REG_T_CKSRX  = 4'h8;
  localparam logic [REG_AW-1:0] REG_T_DLLK   = 4'h9;
  localparam logic [REG_AW-1:0] REG_T_ZQOPER = 4'ha;
  localparam logic [REG_AW-1:0] REG_MR0      = 4'hb;
  localparam logic [REG_AW-1:0] REG_MR1      = 4'hc;
  localparam logic [REG_AW-1:0] REG_MR2      = 4'hd;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_GO     = 0;
  localparam int CTRL_TO_OFF = 1;
  localparam int CTRL_ZQ_EN  = 2;
  localparam int CTRL_ODT    = 3;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DLLOFF = 1;
  localparam int STAT_DONE   = 2;
  localparam int MR1_DLL_DIS = 0;
  localparam int MR0_DLL_RST = 8;
  localparam int ZQ_LONG_BIT = 10;

  // ----------------------------------------------------------------
  // command codes {cs_n, ras_n, cas_n, we_n} and mode register banks
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_ZQCL = 4'h6;
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
  localparam logic [BA_W-1:0] BA_MR2 = 3'h2;

  // ----------------------------------------------------------------
  // clocking and reset values
  // ----------------------------------------------------------------
  localparam int SYS_CK_PS = 100000;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h04;
  localparam int CK_PS_RST = 2 * 4 * SYS_CK_PS;
  localparam int T_XS_NS   = 170;
  localparam int T_CKSRE_NS = 10;
  localparam int T_CKSRX_NS = 10;

  // ns to whole clock cycles, rounded up
  function automatic logic [CNT_W-1:0] ns_to_nck(input int ns,
                                                 input int ck_ps);
    int n;
    n = (ns * 1000 + ck_ps - 1) / ck_ps;
    if (n < 1) n = 1;
    return CNT_W'(n);
  endfunction

  localparam logic [CNT_W-1:0] T_MOD_RST    = 10'h00c;
  localparam logic [CNT_W-1:0] T_MRD_RST    = 10'h004;
  localparam logic [CNT_W-1:0] T_XS_RST     = ns_to_nck(T_XS_NS, CK_PS_RST);
  localparam logic [CNT_W-1:0] T_CKSRE_RST  = 10'h005;
  localparam logic [CNT_W-1:0] T_CKSRX_RST  = 10'h005;
  localparam logic [CNT_W-1:0] T_DLLK_RST   = 10'h200;
  localparam logic [CNT_W-1:0] T_ZQOPER_RST = 10'h100;
  localparam logic [DATA_W-1:0] MR_RST      = 16'h0000;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_DLL_DIS, S_W_MOD_SRE, S_W_CKSRE, S_W_CKSRX, S_SRX,
    S_W_XS, S_DLL_RST, S_MR2, S_W_FIN, S_W_ZQ, S_W_LOCK
  } dms_state_t;

endpackage

// File: dms_wait_cnt.sv
// down counter of memory clock edges for one wait interval
`timescale 1ns/1ps
module dms_wait_cnt
  import dms_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         tick_i,
  output logic              done_o
);

  logic [W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // load wins over a tick, stops at zero
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= value_i;
    end else if (tick_i && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign done_o = (cnt_r == '0);

endmodule

// File: dms_ck_div.sv
// memory clock generator: divides the system clock, marks its edges
`timescale 1ns/1ps
module dms_ck_div
  import dms_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] half_i,
  output logic              ck_o,
  output logic              rise_o,
  output logic              fall_o
);

  logic [W-1:0] hc_r;
  logic         wrap;

  // half period in system cycles, zero treated as one
  assign wrap = (hc_r + W'(1) >= half_i);

  // ----------------------------------------------------------------
  // toggle and edge pulses; a new ratio applies at once, compared against the running half-period count
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hc_r   <= '0;
      ck_o   <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= wrap && !ck_o;
      fall_o <= wrap && ck_o;
      if (wrap) begin
        hc_r <= '0;
        ck_o <= !ck_o;
      end else begin
        hc_r <= hc_r + W'(1);
      end
    end
  end

endmodule

// File: dms_seq.sv
// dll on/off switch sequencer driving a ddr3 device through self refresh
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
//
// Contract
// - idle, all banks precharged, termination off before dll-disable write
// - after dll-disable wait tmod, enter self refresh, hold clock tcksre
// - new clock stable for tcksrx before self refresh exit
// - toward dll-off, cke high from exit until tmod after every mrs
// - toward dll-off, odt low until all tmod intervals end
// - toward dll-off, wait txs then reprogram mode registers, zqcl allowed
// - toward dll-on, start idle with termination off, wait tcksre
// - toward dll-on, cke high from exit until tdllk after dll reset
// - toward dll-on, odt low until tdllk after dll reset
// - toward dll-on, wait txs then write mr1 a0 zero
// - after dll enable, wait tmrd then mr0 a8 one for dll reset
// - after dll reset wait tmrd, reprogram; zqcl once tmod met
// - no dll-dependent command before tdllk; also tzqoper after zqcl
// - clock-cycle intervals count actual memory clock edges
// - nanosecond timings become cycles divided by period, rounded up
module dms_seq
  import dms_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic [REG_AW-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   ck_o,
  output logic                   cke_o,
  output logic                   cs_n_o,
  output logic                   ras_n_o,
  output logic                   cas_n_o,
  output logic                   we_n_o,
  output logic      [BA_W-1:0]   ba_o,
  output logic      [ADDR_W-1:0] a_o,
  output logic                   odt_o,
  output logic                   busy_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dms_state_t        state_r, state_nxt;
  logic              to_off_r;
  logic              zq_en_r;
  logic              odt_idle_r;
  logic              dll_off_r;
  logic              done_r;
  logic [DIV_W-1:0]  div_new_r;
  logic [DIV_W-1:0]  div_cur_r;
  logic [CNT_W-1:0]  t_mod_r;
  logic [CNT_W-1:0]  t_mrd_r;
  logic [CNT_W-1:0]  t_xs_r;
  logic [CNT_W-1:0]  t_cksre_r;
  logic [CNT_W-1:0]  t_cksrx_r;
  logic [CNT_W-1:0]  t_dllk_r;
  logic [CNT_W-1:0]  t_zqoper_r;
  logic [DATA_W-1:0] mr0_r;
  logic [DATA_W-1:0] mr1_r;
  logic [DATA_W-1:0] mr2_r;
  logic              rise_w;
  logic              fall_w;
  logic              wait_done_w;
  logic              lock_done_w;
  logic              go_w;
  logic              launch_w;
  logic              issue;
  logic [3:0]        cmd_nxt;
  logic [BA_W-1:0]   ba_nxt;
  logic [ADDR_W-1:0] a_nxt;
  logic              wload;
  logic [CNT_W-1:0]  wval;
  logic              lock_load;
  logic              cke_lo;
  logic              cke_hi;
  logic              div_swap;
  logic              finish;

  // mode register value cut to the address pins
  function automatic logic [ADDR_W-1:0] mr_a(input logic [DATA_W-1:0] v);
    return v[ADDR_W-1:0];
  endfunction

  // widen a small field into a read word
  function automatic logic [DATA_W-1:0] rd_w(input logic [CNT_W-1:0] v);
    return {{(DATA_W-CNT_W){1'b0}}, v};
  endfunction

  assign go_w     = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_GO];
  // commands launch on a falling memory clock edge once the wait expired
  assign launch_w = fall_w && wait_done_w;

  // ----------------------------------------------------------------
  // memory clock and the two wait counters
  // ----------------------------------------------------------------
  dms_ck_div #(.W(DIV_W)) u_div (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .half_i  (div_cur_r),
    .ck_o    (ck_o),
    .rise_o  (rise_w),
    .fall_o  (fall_w)
  );

  // step wait: counts rising memory clock edges after a launch
  dms_wait_cnt #(.W(CNT_W)) u_wait (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .load_i  (wload),
    .value_i (wval),
    .tick_i  (rise_w),
    .done_o  (wait_done_w)
  );

  // lock wait: runs beside the step wait from the dll reset
  dms_wait_cnt #(.W(CNT_W)) u_lock (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .load_i  (lock_load),
    .value_i (t_dllk_r),
    .tick_i  (rise_w),
    .done_o  (lock_done_w)
  );

  // ----------------------------------------------------------------
  // sequencer next state and command choice
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    issue     = 1'b0;
    cmd_nxt   = CMD_NOP;
    ba_nxt    = '0;
    a_nxt     = '0;
    wload     = 1'b0;
    wval      = '0;
    lock_load = 1'b0;
    cke_lo    = 1'b0;
    cke_hi    = 1'b0;
    div_swap  = 1'b0;
    finish    = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        // software starts only from idle with banks precharged
        if (go_w) begin
          state_nxt = wdata_i[CTRL_TO_OFF] ? S_DLL_DIS : S_W_MOD_SRE;
        end
      end
      S_DLL_DIS: begin
        if (launch_w) begin
          issue     = 1'b1;
          cmd_nxt   = CMD_MRS;
          ba_nxt    = BA_MR1;
          a_nxt     = mr_a(mr1_r) | ADDR_W'(1 << MR1_DLL_DIS);
          wload     = 1'b1;
          wval      = t_mod_r;
          state_nxt = S_W_MOD_SRE;
        end
      end
      S_W_MOD_SRE: begin
        if (launch_w) begin
          issue     = 1'b1;
          cmd_nxt   = CMD_REF;
          cke_lo    = 1'b1;
          wload     = 1'b1;
          wval      = t_cksre_r;
          state_nxt = S_W_CKSRE;
        end
      end
      S_W_CKSRE: begin
        // the entry edge is the first tick, so swap one rise later
        // and keep every period up to entry plus the wait unchanged
        if (rise_w && wait_done_w) begin
          div_swap  = 1'b1;
          wload     = 1'b1;
          wval      = t_cksrx_r;
          state_nxt = S_W_CKSRX;
        end
      end
      S_W_CKSRX: begin
        if (launch_w) begin
          issue     = 1'b1;
          cmd_nxt   = CMD_NOP;
          cke_hi    = 1'b1;
          wload     = 1'b1;
          wval      = t_xs_r;
          state_nxt = S_W_XS;
        end
      end
      S_W_XS: begin
        if (launch_w) begin
          issue  = 1'b1;
          cmd_nxt = CMD_MRS;
          wload  = 1'b1;
          wval   = t_mrd_r;
          if (to_off_r) begin
            ba_nxt    = BA_MR0;
            a_nxt     = mr_a(mr0_r) & ~ADDR_W'(1 << MR0_DLL_RST);
            state_nxt = S_MR2;
          end else begin
            ba_nxt    = BA_MR1;
            a_nxt     = mr_a(mr1_r) & ~ADDR_W'(1 << MR1_DLL_DIS);
            state_nxt = S_DLL_RST;
          end
        end
      end
      S_DLL_RST: begin
        if (launch_w) begin
          issue     = 1'b1;
          cmd_nxt   = CMD_MRS;
          ba_nxt    = BA_MR0;
          a_nxt     = mr_a(mr0_r) | ADDR_W'(1 << MR0_DLL_RST);
          wload     = 1'b1;
          wval      = t_mrd_r;
          lock_load = 1'b1;
          state_nxt = S_MR2;
        end
      end
      S_MR2: begin
        if (launch_w) begin
          issue     = 1'b1;
          cmd_nxt   = CMD_MRS;
          ba_nxt    = BA_MR2;
          a_nxt     = mr_a(mr2_r);
          wload     = 1'b1;
          wval      = t_mod_r;
          state_nxt = S_W_FIN;
        end
      end
      S_W_FIN: begin
        // zqcl only once tmod from the last mode write has passed
        if (launch_w) begin
          if (zq_en_r) begin
            issue     = 1'b1;
            cmd_nxt   = CMD_ZQCL;
            a_nxt     = ADDR_W'(1 << ZQ_LONG_BIT);
            wload     = 1'b1;
            wval      = t_zqoper_r;
            state_nxt = S_W_ZQ;
          end else begin
            state_nxt = S_W_LOCK;
          end
        end
      end
      S_W_ZQ: begin
        if (wait_done_w) begin
          state_nxt = S_W_LOCK;
        end
      end
      S_W_LOCK: begin
        // no dll-dependent traffic handed back before lock time
        if (wait_done_w && lock_done_w) begin
          finish    = 1'b1;
          state_nxt = S_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state and run settings
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r  <= S_IDLE;
      to_off_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == S_IDLE && go_w) begin
        to_off_r <= wdata_i[CTRL_TO_OFF];
      end
    end
  end

  // command pins change on the falling memory clock edge only
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
      ba_o <= '0;
      a_o  <= '0;
    end else if (fall_w) begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= issue ? cmd_nxt : CMD_NOP;
      ba_o <= issue ? ba_nxt : '0;
      a_o  <= issue ? a_nxt : '0;
    end
  end

  // cke low only in self refresh, high from exit to the end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cke_o <= 1'b1;
    end else if (cke_lo) begin
      cke_o <= 1'b0;
    end else if (cke_hi) begin
      cke_o <= 1'b1;
    end
  end

  // odt held low through the whole switch
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      odt_o  <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      odt_o  <= (state_nxt == S_IDLE) ? odt_idle_r : 1'b0;
      busy_o <= (state_nxt != S_IDLE);
    end
  end

  // divider ratio swapped only inside self refresh
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      div_cur_r <= DIV_RST;
    end else if (div_swap) begin
      div_cur_r <= div_new_r;
    end
  end

  // dll mode reached and sticky completion flag, set wins over clear
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dll_off_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      if (finish) begin
        dll_off_r <= to_off_r;
      end
      if (finish) begin
        done_r <= 1'b1;
      end else if (wr_i && addr_i == REG_STATUS && wdata_i[STAT_DONE]) begin
        done_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // software writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      zq_en_r    <= 1'b0;
      odt_idle_r <= 1'b0;
      div_new_r  <= DIV_RST;
      t_mod_r    <= T_MOD_RST;
      t_mrd_r    <= T_MRD_RST;
      t_xs_r     <= T_XS_RST;
      t_cksre_r  <= T_CKSRE_RST;
      t_cksrx_r  <= T_CKSRX_RST;
      t_dllk_r   <= T_DLLK_RST;
      t_zqoper_r <= T_ZQOPER_RST;
      mr0_r      <= MR_RST;
      mr1_r      <= MR_RST;
      mr2_r      <= MR_RST;
    end else if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: begin
          zq_en_r    <= wdata_i[CTRL_ZQ_EN];
          odt_idle_r <= wdata_i[CTRL_ODT];
        end
        REG_DIV_NEW:  div_new_r  <= wdata_i[DIV_W-1:0];
        REG_T_MOD:    t_mod_r    <= wdata_i[CNT_W-1:0];
        REG_T_MRD:    t_mrd_r    <= wdata_i[CNT_W-1:0];
        REG_T_XS:     t_xs_r     <= wdata_i[CNT_W-1:0];
        REG_T_CKSRE:  t_cksre_r  <= wdata_i[CNT_W-1:0];
        REG_T_CKSRX:  t_cksrx_r  <= wdata_i[CNT_W-1:0];
        REG_T_DLLK:   t_dllk_r   <= wdata_i[CNT_W-1:0];
        REG_T_ZQOPER: t_zqoper_r <= wdata_i[CNT_W-1:0];
        REG_MR0:      mr0_r      <= wdata_i;
        REG_MR1:      mr1_r      <= wdata_i;
        REG_MR2:      mr2_r      <= wdata_i;
        default: ;
      endcase
    end
  end

  // read data valid in the cycle after the read strobe, else zero
  always_ff @(posedge clock_i) begin
    if (reset_i || !rd_i) begin
      rdata_o <= '0;
    end else begin
      unique case (addr_i)
        REG_CTRL: rdata_o <= DATA_W'({odt_idle_r, zq_en_r, to_off_r, 1'b0});
        REG_STATUS: rdata_o <= DATA_W'({done_r, dll_off_r, busy_o});
        REG_DIV_NEW:  rdata_o <= DATA_W'(div_new_r);
        REG_DIV_CUR:  rdata_o <= DATA_W'(div_cur_r);
        REG_T_MOD:    rdata_o <= rd_w(t_mod_r);
        REG_T_MRD:    rdata_o <= rd_w(t_mrd_r);
        REG_T_XS:     rdata_o <= rd_w(t_xs_r);
        REG_T_CKSRE:  rdata_o <= rd_w(t_cksre_r);
        REG_T_CKSRX:  rdata_o <= rd_w(t_cksrx_r);
        REG_T_DLLK:   rdata_o <= rd_w(t_dllk_r);
        REG_T_ZQOPER: rdata_o <= rd_w(t_zqoper_r);
        REG_MR0:      rdata_o <= mr0_r;
        REG_MR1:      rdata_o <= mr1_r;
        REG_MR2:      rdata_o <= mr2_r;
        default:      rdata_o <= '0;
      endcase
    end
  end

endmodule

// File: dms_seq_asserts.sv
// concurrent checks on the sequencer's register strobe and memory pins
`timescale 1ns/1ps
module dms_seq_asserts
  import dms_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              reset_i,
  input wire logic [REG_AW-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              ck_o,
  input wire logic              cke_o,
  input wire logic              cs_n_o,
  input wire logic              ras_n_o,
  input wire logic              cas_n_o,
  input wire logic              we_n_o,
  input wire logic [ADDR_W-1:0] a_o,
  input wire logic              odt_o,
  input wire logic              busy_o
);
  logic [3:0] cmd;
  logic       go;
  // command code and start strobe
  assign cmd = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
  assign go  = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_GO];
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_odt_low_run: assert property (busy_o && $past(busy_o) |-> !odt_o)
    else $error("odt high during a switch");
  a_cmd_on_fall: assert property (!$stable(cmd) |-> !ck_o)
    else $error("command changed while memory clock high");
  a_cke_fall_sre: assert property ($fell(cke_o) |-> cmd == CMD_REF)
    else $error("cke dropped without self refresh entry");
  a_sre_in_run: assert property ($fell(cke_o) |-> busy_o && !odt_o)
    else $error("self refresh outside a switch");
  a_cke_rise_nop: assert property ($rose(cke_o) |-> cmd == CMD_NOP)
    else $error("self refresh exit not a nop");
  a_no_cmd_pair: assert property (!$stable(cmd) && cmd != CMD_NOP
    |-> $past(cmd) == CMD_NOP)
    else $error("two commands without a nop between");
  a_idle_quiet: assert property (!busy_o && !$past(busy_o)
    |-> cmd == CMD_NOP && cke_o)
    else $error("idle pins not quiet");
  a_go_starts: assert property (go && !busy_o |=> busy_o)
    else $error("start request not taken");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(go))
    else $error("busy without a start request");
  a_zq_long: assert property (cmd == CMD_ZQCL |-> a_o[ZQ_LONG_BIT] && cke_o)
    else $error("calibration command malformed");
endmodule

bind dms_seq dms_seq_asserts u_chk (
  .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .ck_o(ck_o), .cke_o(cke_o),
  .cs_n_o(cs_n_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o),
  .we_n_o(we_n_o), .a_o(a_o), .odt_o(odt_o), .busy_o(busy_o));

// File: dms_dram_model.sv
// behavioural ddr3 device that decodes the sequencer's pins
`timescale 1ns/1ps
module dms_dram_model
  import dms_pkg::*;
#(
  parameter int TMRD = 2, TMOD = 3, TSRE = 2, TSRX = 2
) (
  input  wire logic              ck_i,
  input  wire logic              rst_i,
  input  wire logic              cke_i,
  input  wire logic [3:0]        cmd_i,
  input  wire logic [BA_W-1:0]   ba_i,
  input  wire logic [ADDR_W-1:0] a_i,
  output logic                   dll_off_o,
  output logic      [ADDR_W-1:0] mr0_o,
  output logic      [ADDR_W-1:0] mr2_o,
  output int                     zq_o,
  output int                     bad_o
);
  logic    in_sr, after_mrs;
  int      gap, sr_n, new_n;
  realtime t_last, per, per_sr;
  // power-up state; bad_o counts timing breaches
  initial begin
    {dll_off_o, in_sr, after_mrs, mr0_o, mr2_o} = '0;
    {zq_o, bad_o, gap, sr_n, new_n} = '0;
    t_last = 0.0;
    per_sr = 0.0;
  end
  // controller reset drops open self refresh bookkeeping
  always @(posedge rst_i) begin
    in_sr = 1'b0;
    after_mrs = 1'b0;
  end
  // decode pins at each rising memory clock edge
  always @(posedge ck_i) begin
    per = $realtime - t_last;
    t_last = $realtime;
    gap++;
    sr_n++;
    new_n++;
    if (in_sr) begin
      if (per != per_sr) begin
        if (sr_n <= TSRE) bad_o++;
        per_sr = per;
        new_n = 0;
      end
      if (cke_i) begin
        in_sr = 1'b0;
        if (new_n + 1 < TSRX) bad_o++;
      end
    end else if (cmd_i != CMD_NOP) begin
      if (after_mrs && gap < (cmd_i == CMD_MRS ? TMRD : TMOD)) bad_o++;
      after_mrs = (cmd_i == CMD_MRS);
      if (cmd_i == CMD_REF && !cke_i) begin
        in_sr = 1'b1;
        sr_n = 0;
        per_sr = per;
      end
      if (cmd_i == CMD_ZQCL) zq_o++;
      if (cmd_i == CMD_MRS) begin
        gap = 0;
        case (ba_i)
          BA_MR0: mr0_o = a_i;
          BA_MR1: dll_off_o = a_i[MR1_DLL_DIS];
          BA_MR2: mr2_o = a_i;
          default: ;
        endcase
      end
    end
  end
endmodule

// File: dll_mode_switch_sequencer_test.sv
// self-checking bench for the dll mode switch sequencer
`timescale 1ns/1ps
module dll_mode_switch_sequencer_test;
  import dms_pkg::*;
  typedef struct packed {
    logic       off;
    logic       zq;
    logic       odt;
    logic [7:0] div;
  } dms_row_t;
  localparam dms_row_t ROWS [4] = '{{1'b1, 1'b0, 1'b1, 8'h02},
    {1'b0, 1'b1, 1'b0, 8'h03}, {1'b1, 1'b1, 1'b0, 8'h04},
    {1'b0, 1'b0, 1'b1, 8'h02}};
  localparam logic [DATA_W-1:0] TV [7] = '{16'h3, 16'h2, 16'h2,
    16'h2, 16'h2, 16'h6, 16'h3};
  localparam logic [DATA_W-1:0] RV [7] = '{DATA_W'(T_MOD_RST),
    DATA_W'(T_MRD_RST), DATA_W'(T_XS_RST), DATA_W'(T_CKSRE_RST),
    DATA_W'(T_CKSRX_RST), DATA_W'(T_DLLK_RST), DATA_W'(T_ZQOPER_RST)};
  logic              clock_i, reset_i, wr_i, rd_i, ck_o, cke_o;
  logic              cs_n_o, ras_n_o, cas_n_o, we_n_o, odt_o, busy_o;
  logic              m_off;
  logic [REG_AW-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, v;
  logic [BA_W-1:0]   ba_o;
  logic [ADDR_W-1:0] a_o, m_mr0, m_mr2;
  int                num_errors, tests_run, m_zq, m_bad, zq0, i, j;
  dms_row_t          r;

  dms_seq uut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ck_o(ck_o), .cke_o(cke_o), .cs_n_o(cs_n_o), .ras_n_o(ras_n_o),
    .cas_n_o(cas_n_o), .we_n_o(we_n_o), .ba_o(ba_o), .a_o(a_o),
    .odt_o(odt_o), .busy_o(busy_o));
  dms_dram_model #(.TMRD(2), .TMOD(3), .TSRE(2), .TSRX(2)) dram (
    .ck_i(ck_o), .rst_i(reset_i), .cke_i(cke_o),
    .cmd_i({cs_n_o, ras_n_o, cas_n_o, we_n_o}), .ba_i(ba_o), .a_i(a_o),
    .dll_off_o(m_off), .mr0_o(m_mr0), .mr2_o(m_mr2), .zq_o(m_zq),
    .bad_o(m_bad));

  // 10 MHz system clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // compare and count
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask
  // bounded wait for the sequence to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 5000) begin
      @(negedge clock_i);
      n++;
    end
    chk(DATA_W'(busy_o), 16'h0);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #2000000;
    num_errors++;
    summarize;
  end
  // main sequence
  initial begin
    {wr_i, rd_i, addr_i, wdata_i} = '0;
    {num_errors, tests_run} = '0;
    reset_i = 1'b1;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    for (j = 0; j < 7; j++) begin
      rd(REG_T_MOD + REG_AW'(j), v);
      chk(v, RV[j]);
      wr(REG_T_MOD + REG_AW'(j), TV[j]);
    end
    rd(REG_STATUS, v);
    chk(v, 16'h0);
    wr(4'hf, 16'hffff);
    rd(4'hf, v);
    chk(v, 16'h0);
    wr(REG_DIV_CUR, 16'h0009);
    rd(REG_DIV_CUR, v);
    chk(v, DATA_W'(DIV_RST));
    wr(REG_MR0, 16'h0b30);
    wr(REG_MR1, 16'h0006);
    wr(REG_MR2, 16'h0018);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      r = ROWS[i];
      zq0 = m_zq;
      wr(REG_DIV_NEW, DATA_W'(r.div));
      wr(REG_CTRL, {12'h0, r.odt, r.zq, r.off, 1'b1});
      wr(REG_CTRL, {12'h0, r.odt, r.zq, !r.off, 1'b1});
      wait_idle;
      chk(DATA_W'(m_off), DATA_W'(r.off));
      chk(DATA_W'(m_mr0), r.off ? 16'h0a30 : 16'h0b30);
      chk(DATA_W'(m_mr2), 16'h0018);
      chk(DATA_W'(m_zq - zq0), DATA_W'(r.zq));
      chk(DATA_W'(m_bad), 16'h0);
      chk(DATA_W'(odt_o), DATA_W'(r.odt));
      rd(REG_STATUS, v);
      chk(v, {13'h0, 1'b1, r.off, 1'b0});
      rd(REG_DIV_CUR, v);
      chk(v, DATA_W'(r.div));
      wr(REG_STATUS, 16'h0004);
      rd(REG_STATUS, v);
      chk(v, {14'h0, r.off, 1'b0});
      $display("row %0d done", i);
    end
    // reset while the device sits in self refresh
    wr(REG_CTRL, 16'h0003);
    j = 0;
    while (cke_o !== 1'b0 && j < 3000) begin
      @(negedge clock_i);
      j++;
    end
    chk(DATA_W'(cke_o), 16'h0);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk(DATA_W'({busy_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o}),
        16'h0017);
    rd(REG_DIV_CUR, v);
    chk(v, DATA_W'(DIV_RST));
    $display("mid-run reset done");
    summarize;
  end
endmodule
